// file: rtl/slb_consts.vh
// Constants for the serial link self-test controller.
`ifndef SLB_CONSTS_VH
`define SLB_CONSTS_VH
`define SLB_ADDR_ERR_COUNT 8'h57
`define SLB_ADDR_CONTROL 8'hb3
`define SLB_ADDR_REMOTE_ACT 8'hd0
`define SLB_CTL_ENABLE_BIT 0
`define SLB_CTL_CLKSEL_LO 1
`define SLB_CTL_CLKSEL_HI 2
`define SLB_CTL_OUTGATE_LO 6
`define SLB_CTL_OUTGATE_HI 7
`define SLB_CTL_RESET 8'h00
`define SLB_REMOTE_ACT_BIT 5
`define SLB_OUTGATE_OFF 2'b00
`define SLB_OUTGATE_ON 2'b10
`define SLB_CLKSEL_EXTERNAL 2'b00
`define SLB_ERR_NOLOCK 8'hff
`define SLB_ERR_MAX 8'hfe
`define SLB_SER_CLK_REG 8'h14
`define SLB_SER_CLK_MASK 8'hf9
`define SLB_SER_TEST_REG 8'hb3
`define SLB_SER_TEST_ON 8'h01
`define SLB_SER_TEST_OFF 8'h00
`endif

// file: rtl/slb_port_check.v
// Per receive port error counter and pass indication for the link self test.
`include "slb_consts.vh"
module slb_port_check (
	input wire mclk,
	input wire reset,
	input wire test_start,
	input wire test_active,
	input wire rx_lock,
	input wire pattern_error,
	output wire [7:0] error_count,
	output wire pass
);
	reg [7:0] count_ff;
	reg [7:0] nxt_count;
	reg lock_seen_ff;
	reg nxt_lock_seen;
	reg lock_lost_ff;
	reg nxt_lock_lost;
	reg pass_ff;
	reg nxt_pass;

	always @* begin
		nxt_count = count_ff;
		nxt_lock_seen = lock_seen_ff;
		nxt_lock_lost = lock_lost_ff;
		nxt_pass = 1'b1;
		// R18: clear at start
		if (test_start) begin
			nxt_count = 8'h00;
			nxt_lock_seen = 1'b0;
			nxt_lock_lost = 1'b0;
		end else if (test_active) begin
			if (rx_lock) begin
				nxt_lock_seen = 1'b1;
			end else if (lock_seen_ff) begin
				nxt_lock_lost = 1'b1;
			end
			// R19: saturate at maximum
			if (rx_lock && pattern_error && count_ff < `SLB_ERR_MAX) begin
				nxt_count = count_ff + 8'h01;
			end
			// R11: pass drops per error
			if (pattern_error) begin
				nxt_pass = 1'b0;
			end
		end
	end

	always @(posedge mclk) begin
		if (reset) begin
			count_ff <= 8'h00;
			lock_seen_ff <= 1'b0;
			lock_lost_ff <= 1'b0;
			pass_ff <= 1'b1;
		end else begin
			count_ff <= nxt_count;
			lock_seen_ff <= nxt_lock_seen;
			lock_lost_ff <= nxt_lock_lost;
			pass_ff <= nxt_pass;
		end
	end

	// R12: no lock reads as full
	assign error_count = (lock_seen_ff && !lock_lost_ff) ? count_ff : `SLB_ERR_NOLOCK;
	assign pass = pass_ff;
endmodule

// file: rtl/slb_selftest_ctrl.v
// Serial link self-test controller: start, remote setup, checking and output gating.
// Summary of operation
// R1: Test runs while the enable pin is high or the control enable bit is set.
// R2: On start, write the remote serializer's test setup over the back channel.
// R3: The remote serializer sends an unbroken random pattern at full speed.
// R4: Check the received pattern and count errors per receive port.
// R5: The remote serializer counts back-channel check-field errors.
// R6: Lock, pass and line monitor outputs keep working during the test.
// R7: Pin start copies the two pin levels into the remote clock-select field.
// R8: Clock-select pins are sampled once at the enable pin rising edge.
// R9: Software avoids clock-select 11 with older serializers.
// R10: Any port's pass indication may be routed to a general pin.
// R11: Pass goes low for each data error on the selected port.
// R12: Counter reads ff without lock, otherwise never above fe.
// R13: A readable bit shows self test active in the remote serializer.
// R14: Output gating 00 disables outputs, 10 enables them during test.
// R15: With outputs enabled the transmitter rests in LP11 unless generator runs.
// R16: Register start writes the clock-source field, sampled only at start.
// R17: Software also routes each port's lock status to a general pin; the code routes only pass to the pin, lock shows only as lock_all.
// R18: Counters clear at test start and hold their value after the end.
// R19: Counter saturates instead of wrapping while lock holds.
`include "slb_consts.vh"
module slb_selftest_ctrl #(
	parameter NUM_PORTS = 2,
	parameter PORT_BITS = 1
) (
	input wire mclk,
	input wire reset,
	input wire link_selftest_enable_pin,
	input wire [1:0] clock_select_pins,
	input wire reg_wr,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire [PORT_BITS-1:0] reg_port,
	output reg [7:0] reg_rdata,
	input wire [NUM_PORTS-1:0] rx_lock,
	input wire [NUM_PORTS-1:0] pattern_error,
	input wire [NUM_PORTS-1:0] remote_selftest_active,
	input wire [PORT_BITS-1:0] pin_function_select,
	output wire pass_to_pin,
	output wire pass_all,
	output wire lock_all,
	input wire line_monitor_in,
	output wire line_monitor_output,
	output wire selftest_active,
	output wire outputs_enabled,
	input wire pattern_gen_enable,
	output wire csi_hold_lp11,
	output reg bc_wr_valid,
	output reg [7:0] bc_wr_addr,
	output reg [7:0] bc_wr_data,
	input wire bc_wr_ready
);
	localparam ST_IDLE = 2'd0;
	localparam ST_CLK = 2'd1;
	localparam ST_ON = 2'd2;
	localparam ST_RUN = 2'd3;

	reg [7:0] ctl_ff;
	reg en_meta_ff;
	reg en_sync_ff;
	reg en_prev_ff;
	reg [1:0] gp_meta_ff;
	reg [1:0] gp_sync_ff;
	reg [NUM_PORTS-1:0] ract_meta_ff;
	reg [NUM_PORTS-1:0] ract_sync_ff;
	reg active_ff;
	reg [1:0] clksel_ff;
	reg [1:0] state_ff;
	reg [1:0] nxt_state;
	reg stop_pend_ff;
	wire want_test;
	wire test_start;
	wire test_end;
	wire [NUM_PORTS-1:0] pass_vec;
	wire [8*NUM_PORTS-1:0] count_vec;

	always @(posedge mclk) begin
		if (reset) begin
			en_meta_ff <= 1'b0;
			en_sync_ff <= 1'b0;
			en_prev_ff <= 1'b0;
			gp_meta_ff <= 2'b00;
			gp_sync_ff <= 2'b00;
			ract_meta_ff <= {NUM_PORTS{1'b0}};
			ract_sync_ff <= {NUM_PORTS{1'b0}};
		end else begin
			en_meta_ff <= link_selftest_enable_pin;
			en_sync_ff <= en_meta_ff;
			en_prev_ff <= en_sync_ff;
			gp_meta_ff <= clock_select_pins;
			gp_sync_ff <= gp_meta_ff;
			ract_meta_ff <= remote_selftest_active;
			ract_sync_ff <= ract_meta_ff;
		end
	end

	// R1: pin or register start
	assign want_test = en_sync_ff | ctl_ff[`SLB_CTL_ENABLE_BIT];
	assign test_start = want_test & ~active_ff;
	assign test_end = ~want_test & active_ff;

	always @(posedge mclk) begin
		if (reset) begin
			ctl_ff <= `SLB_CTL_RESET;
			active_ff <= 1'b0;
			clksel_ff <= `SLB_CLKSEL_EXTERNAL;
		end else begin
			if (reg_wr && reg_addr == `SLB_ADDR_CONTROL) begin
				ctl_ff <= reg_wdata;
			end
			active_ff <= want_test;
			if (test_start) begin
				// R8: pins sampled on enable rise
				// R7: pin start uses pin levels
				if (en_sync_ff && !en_prev_ff) begin
					clksel_ff <= gp_sync_ff;
				end else begin
					// R16: register field sampled once
					clksel_ff <= ctl_ff[`SLB_CTL_CLKSEL_HI:`SLB_CTL_CLKSEL_LO];
				end
			end
		end
	end

	// R2: back-channel setup writes
	always @* begin
		nxt_state = state_ff;
		bc_wr_valid = 1'b0;
		bc_wr_addr = 8'h00;
		bc_wr_data = 8'h00;
		case (state_ff)
			ST_IDLE: begin
				if (test_start) begin
					nxt_state = ST_CLK;
				end else if (stop_pend_ff) begin
					bc_wr_valid = 1'b1;
					bc_wr_addr = `SLB_SER_TEST_REG;
					bc_wr_data = `SLB_SER_TEST_OFF;
				end
			end
			ST_CLK: begin
				bc_wr_valid = 1'b1;
				bc_wr_addr = `SLB_SER_CLK_REG;
				bc_wr_data = {5'h00, clksel_ff, 1'b0};
				if (bc_wr_ready) begin
					nxt_state = ST_ON;
				end
			end
			ST_ON: begin
				bc_wr_valid = 1'b1;
				bc_wr_addr = `SLB_SER_TEST_REG;
				bc_wr_data = `SLB_SER_TEST_ON;
				if (bc_wr_ready) begin
					nxt_state = ST_RUN;
				end
			end
			default: begin
				// A restart that comes before the return to idle must still program the remote.
				if (test_start) begin
					nxt_state = ST_CLK;
				end else if (!active_ff) begin
					nxt_state = ST_IDLE;
				end
			end
		endcase
	end

	always @(posedge mclk) begin
		if (reset) begin
			state_ff <= ST_IDLE;
			stop_pend_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			if (test_end) begin
				stop_pend_ff <= 1'b1;
			end else if (test_start || (state_ff == ST_IDLE && bc_wr_ready)) begin
				stop_pend_ff <= 1'b0;
			end
		end
	end

	// R4: one checker per port
	genvar gi;
	generate
		for (gi = 0; gi < NUM_PORTS; gi = gi + 1) begin : g_port
			slb_port_check u_check (
				.mclk(mclk),
				.reset(reset),
				.test_start(test_start),
				.test_active(active_ff),
				.rx_lock(rx_lock[gi]),
				.pattern_error(pattern_error[gi]),
				.error_count(count_vec[8*gi+7:8*gi]),
				.pass(pass_vec[gi])
			);
		end
	endgenerate

	// R10: pass routed to pin
	assign pass_to_pin = pass_vec[pin_function_select];
	// R6: indications stay live
	assign pass_all = &pass_vec;
	assign lock_all = &rx_lock;
	assign line_monitor_output = line_monitor_in;
	assign selftest_active = active_ff;
	// R14: output gating field
	assign outputs_enabled = ~active_ff |
		(ctl_ff[`SLB_CTL_OUTGATE_HI:`SLB_CTL_OUTGATE_LO] == `SLB_OUTGATE_ON);
	// R15: rest in LP11
	assign csi_hold_lp11 = active_ff & outputs_enabled & ~pattern_gen_enable;

	// R13: remote active readback
	always @* begin
		if (reg_addr == `SLB_ADDR_ERR_COUNT) begin
			reg_rdata = count_vec[8*reg_port +: 8];
		end else if (reg_addr == `SLB_ADDR_CONTROL) begin
			reg_rdata = ctl_ff;
		end else if (reg_addr == `SLB_ADDR_REMOTE_ACT) begin
			reg_rdata = {2'b00, ract_sync_ff[reg_port], 5'h00};
		end else begin
			reg_rdata = 8'h00;
		end
	end
endmodule

// file: dv/slb_monitor.sv
// Assertion checker bound to the self-test controller.
module slb_monitor #(
	parameter NUM_PORTS = 2,
	parameter PORT_BITS = 1
) (
	input wire mclk,
	input wire reset,
	input wire link_selftest_enable_pin,
	input wire [NUM_PORTS-1:0] rx_lock,
	input wire [NUM_PORTS-1:0] pattern_error,
	input wire [PORT_BITS-1:0] pin_function_select,
	input wire pass_to_pin,
	input wire lock_all,
	input wire line_monitor_in,
	input wire line_monitor_output,
	input wire selftest_active,
	input wire outputs_enabled,
	input wire pattern_gen_enable,
	input wire csi_hold_lp11,
	input wire bc_wr_valid,
	input wire [7:0] bc_wr_addr,
	input wire [7:0] bc_wr_data,
	input wire bc_wr_ready
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge mclk);
	endclocking
	default disable iff (reset);
	lock_follow_a: assert property (lock_all == &rx_lock)
		else $error("lock output wrong");
	line_pass_a: assert property (line_monitor_output == line_monitor_in)
		else $error("line monitor wrong");
	pass_drop_a: assert property (selftest_active && rx_lock[pin_function_select]
		&& pattern_error[pin_function_select] |=> !pass_to_pin) else $error("pass kept");
	lp_rest_a: assert property (csi_hold_lp11 ==
		(selftest_active && outputs_enabled && !pattern_gen_enable)) else $error("lp11 wrong");
	idle_open_a: assert property (!selftest_active |-> outputs_enabled)
		else $error("outputs gated when idle");
	bc_hold_a: assert property (bc_wr_valid && !bc_wr_ready |=> bc_wr_valid
		&& $stable(bc_wr_addr) && $stable(bc_wr_data)) else $error("request dropped");
	bc_first_a: assert property ($rose(selftest_active) |-> ##[0:1]
		(bc_wr_valid && bc_wr_addr == 8'h14)) else $error("no clock write");
	pin_start_a: assert property ($rose(link_selftest_enable_pin) |-> ##[1:4]
		selftest_active) else $error("pin start missed");
endmodule

bind slb_selftest_ctrl slb_monitor #(.NUM_PORTS(NUM_PORTS), .PORT_BITS(PORT_BITS)) i_mon (
	.mclk(mclk), .reset(reset), .link_selftest_enable_pin(link_selftest_enable_pin),
	.rx_lock(rx_lock), .pattern_error(pattern_error), .pass_to_pin(pass_to_pin),
	.pin_function_select(pin_function_select), .lock_all(lock_all),
	.line_monitor_in(line_monitor_in), .line_monitor_output(line_monitor_output),
	.selftest_active(selftest_active), .outputs_enabled(outputs_enabled),
	.pattern_gen_enable(pattern_gen_enable), .csi_hold_lp11(csi_hold_lp11),
	.bc_wr_valid(bc_wr_valid), .bc_wr_addr(bc_wr_addr), .bc_wr_data(bc_wr_data),
	.bc_wr_ready(bc_wr_ready));

// file: dv/slb_ser_model.sv
// Remote serializer model answering back-channel register writes.
module slb_ser_model (
	input wire mclk,
	input wire reset,
	input wire bc_wr_valid,
	input wire [7:0] bc_wr_addr,
	input wire [7:0] bc_wr_data,
	output logic bc_wr_ready,
	output logic act,
	output logic [1:0] clk_sel
);
	timeunit 1ns;
	timeprecision 1ns;
	int seed = 32'h0fcd;
	int bc_err = 0;
	// Random stalls on the accept line exercise a slow back channel.
	always @(posedge mclk) begin
		bc_wr_ready <= bc_wr_valid && !bc_wr_ready && ($random(seed) & 1);
		if (bc_wr_valid && bc_wr_ready && bc_wr_addr == 8'h14)
			clk_sel <= bc_wr_data[2:1];
		if (bc_wr_valid && bc_wr_ready && bc_wr_addr == 8'hb3)
			act <= bc_wr_data[0];
		if (bc_wr_valid && bc_wr_ready) begin
			if (bc_wr_addr == 8'h14 && (bc_wr_data[7:3] != 0 || bc_wr_data[0]))
				bc_err <= bc_err + 1;
			else if (bc_wr_addr == 8'hb3 && bc_wr_data[7:1] != 0)
				bc_err <= bc_err + 1;
			else if (bc_wr_addr != 8'h14 && bc_wr_addr != 8'hb3)
				bc_err <= bc_err + 1;
		end
		if (reset) begin
			bc_wr_ready <= 0;
			act <= 0;
		end
	end
endmodule

// file: dv/tb.sv
// Testbench for the serial link self-test controller.
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 0, reset = 1, pin = 0, reg_wr = 0, pgen = 0, lmi = 0, port = 0, psel = 0;
	logic [1:0] cs_pins = 0, lock = 0, perr = 0, clk_sel;
	logic [7:0] addr = 0, wdata = 0, rdata, bca, bcd;
	logic bcv, bcr, act, p2p, pall, lall, lmo, sta, oen, lp11, run = 0;
	int n_fail = 0, n_compared = 0, seed = 32'h0fcd, cnt[2], cs, i;
	always #50 mclk = ~mclk;
	slb_selftest_ctrl i_dut (.mclk(mclk), .reset(reset), .link_selftest_enable_pin(pin),
		.clock_select_pins(cs_pins), .reg_wr(reg_wr), .reg_addr(addr), .reg_wdata(wdata),
		.reg_port(port), .reg_rdata(rdata), .rx_lock(lock), .pattern_error(perr),
		.remote_selftest_active({act, act}), .pin_function_select(psel),
		.pass_to_pin(p2p), .pass_all(pall), .lock_all(lall), .line_monitor_in(lmi),
		.line_monitor_output(lmo), .selftest_active(sta), .outputs_enabled(oen),
		.pattern_gen_enable(pgen), .csi_hold_lp11(lp11), .bc_wr_valid(bcv),
		.bc_wr_addr(bca), .bc_wr_data(bcd), .bc_wr_ready(bcr));
	slb_ser_model i_ser (.mclk(mclk), .reset(reset), .bc_wr_valid(bcv), .bc_wr_addr(bca),
		.bc_wr_data(bcd), .bc_wr_ready(bcr), .act(act), .clk_sel(clk_sel));
	task automatic chk(input logic [7:0] g, e);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		@(posedge mclk);
		reg_wr <= 1;
		addr <= a;
		wdata <= d;
		@(posedge mclk);
		reg_wr <= 0;
	endtask
	task automatic rd(input logic [7:0] a, input logic p, input logic [7:0] e);
		@(posedge mclk);
		addr <= a;
		port <= p;
		#1 chk(rdata, e);
	endtask
	task automatic wact(input logic v);
		repeat (60) if (act !== v) @(posedge mclk);
		chk(act, v);
	endtask
	task automatic errs(input int n);
		logic [1:0] e;
		repeat (n) begin
			e = $random(seed);
			@(posedge mclk);
			perr <= e | 2'b01;
			pgen <= e[1];
			lmi <= e[0];
			for (i = 0; i < 2; i++) begin
				if ((e[i] || i == 0) && lock[i] && run && cnt[i] < 254) begin
					cnt[i]++;
				end
			end
		end
		@(posedge mclk);
		perr <= 0;
		#1 chk(pall, !run);
	endtask
	task automatic conclude;
		$display("compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		#2000000;
		n_fail++;
		conclude;
	end
	initial begin
		repeat (2) @(posedge mclk);
		reset <= 0;
		rd(8'h57, 1, 8'hff);
		rd(8'h10, 0, 8'h00);
		wr(8'h57, 8'h12);
		rd(8'h57, 0, 8'hff);
		lock <= 2'b11;
		psel <= $random(seed);
		cs = {$random(seed)} % 3;
		cnt = '{0, 0};
		run = 1;
		wr(8'hb3, {2'b10, 3'b0, cs[1:0], 1'b1});
		wact(1);
		chk(clk_sel, cs[1:0]);
		wr(8'hb3, {2'b10, 3'b0, cs == 0, 2'b01});
		repeat (4) @(posedge mclk);
		rd(8'hd0, 0, 8'h20);
		chk(clk_sel, cs[1:0]);
		chk(oen, 1);
		errs(300);
		wr(8'hb3, 8'h01);
		#1 chk(oen, 0);
		run = 0;
		wr(8'hb3, 8'h00);
		wact(0);
		errs(5);
		rd(8'h57, 0, cnt[0]);
		rd(8'h57, 1, cnt[1]);
		cs = {$random(seed)} % 3;
		cs_pins <= cs[1:0];
		cnt = '{0, 0};
		run = 1;
		@(posedge mclk);
		pin <= 1;
		repeat (3) @(posedge mclk);
		cs_pins <= ~cs_pins;
		wact(1);
		chk(clk_sel, cs[1:0]);
		rd(8'h57, 0, 8'h00);
		errs(20);
		lock <= 2'b01;
		errs(5);
		chk(lall, &lock);
		rd(8'h57, 1, 8'hff);
		rd(8'h57, 0, cnt[0]);
		pin <= 0;
		wact(0);
		chk(i_ser.bc_err[7:0], 8'h00);
		conclude;
	end
endmodule
